// [fprs_pkg.sv]
package fprs_pkg;

   // Fault codes reported by the protection logic.
   typedef enum logic [4:0] {
      F_OC_ACCEL = 5'h00, F_OC_CONST = 5'h01, F_OC_DECEL = 5'h02,
      F_OV_ACCEL = 5'h03, F_OV_CONST = 5'h04, F_OV_DECEL = 5'h05,
      F_MOTOR_THERMAL = 5'h06, F_DRIVE_THERMAL = 5'h07, F_BRAKE = 5'h08,
      F_EARTH = 5'h09, F_USB = 5'h0a, F_EXT_THERMAL = 5'h0b, F_STALL = 5'h0c,
      F_OPTION = 5'h0d, F_OPTION_COMM = 5'h0e, F_PARAM_STORAGE = 5'h0f,
      F_CPU_A = 5'h10, F_CPU_B = 5'h11, F_CPU_C = 5'h12, F_CPU_D = 5'h13,
      F_INPUT_PHASE_LOSS = 5'h14
   } fprs_fault_t;

   // Software settings, held stable by the parameter store.
   typedef struct packed {
      logic [13:0] coast_time;
      logic [1:0] loss_sel;
      logic [2:0] retry_sel;
      logic [7:0] retry_cnt;
      logic [11:0] wait_time;
      logic [7:0] term_sel;
   } fprs_cfg_t;

   typedef enum logic [1:0] {
      L_RUN = 2'b00, L_DECEL = 2'b01, L_STOPPED = 2'b10, L_COAST = 2'b11
   } fprs_loss_st_t;

   typedef enum logic [1:0] {
      R_IDLE = 2'b00, R_WAIT = 2'b01, R_WATCH = 2'b10, R_LOCK = 2'b11
   } fprs_retry_st_t;

endpackage

// [fprs_regs.svh]
`ifndef FPRS_REGS_SVH
`define FPRS_REGS_SVH

// Core clock rate and the unit of every time setting (0.1 s).
`define FPRS_CLK_MHZ 250
`define FPRS_TICK_MS 100
`define FPRS_TICK_CYCLES (`FPRS_TICK_MS * 1000 * `FPRS_CLK_MHZ)

// Fault-free run that a retry needs, besides a run longer than four waiting times, to count as a success.
`define FPRS_SUCC_MIN_MS 3100
// Retry waiting time used when the setting is zero (1 s, in ticks).
`define FPRS_WAIT_DEFAULT 12'h00a

// Coast time value that means automatic restart is not selected.
`define FPRS_COAST_NONE 14'h270f

// Loss stop selection codes.
`define FPRS_LOSS_COAST 2'h0
`define FPRS_LOSS_STOP 2'h1
`define FPRS_LOSS_CONT 2'h2

// Retry count setting: quiet range top and offset of the loud range.
`define FPRS_QUIET_MAX 8'h0a
`define FPRS_LOUD_BASE 8'h64

// Output terminal function codes.
`define FPRS_TERM_LOSS_POS 8'h2e
`define FPRS_TERM_LOSS_NEG 8'h92
`define FPRS_TERM_RETRY_POS 8'h40
`define FPRS_TERM_RETRY_NEG 8'ha4

// Retry fault masks per selection, bit index equals the fault code.
`define FPRS_NFAULT 21
`define FPRS_MASK_SEL0 21'h1fffff
`define FPRS_MASK_SEL1 21'h000007
`define FPRS_MASK_SEL2 21'h000038
`define FPRS_MASK_SEL3 21'h00003f
`define FPRS_MASK_SEL4 21'h1ff73f
`define FPRS_MASK_SEL5 21'h000005

`endif

// [fprs_seq.sv]
`include "fprs_regs.svh"
module fprs_seq #(
   parameter int TICK_CYCLES = `FPRS_TICK_CYCLES,
   parameter int CNT_W = 16
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic forward_start_input,
   input wire logic reverse_start_input,
   input wire logic supply_loss,
   input wire logic output_at_zero,
   input wire logic fault_trip,
   input wire fprs_pkg::fprs_fault_t fault_code,
   input wire logic powerup_storage_fault,
   input wire logic fault_clear,
   input wire logic counter_write,
   input wire logic [CNT_W-1:0] counter_wdata,
   input wire fprs_pkg::fprs_cfg_t cfg,
   output logic run_permit,
   output logic loss_decel_cmd,
   output logic output_cutoff,
   output logic reaccel_cmd,
   output logic restart_sel_power,
   output logic retry_reset_pulse,
   output logic retry_keep_thermal,
   output logic fault_output,
   output logic retry_excess_fault,
   output logic loss_decel_status_out,
   output logic retry_active_status_out,
   output logic terminal_out,
   output logic [CNT_W-1:0] retry_success_counter
);

   generate
      if (CNT_W < 4) begin : g_chk
         $error("fprs_seq needs CNT_W of at least 4");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Start pins: three flops, a level changes once the last two agree.

   logic [1:0] sync1, sync2, sync3, start_level;
   logic [3:0] sync_fill;
   logic armed;
   logic next_trip;
   logic fault_output_raw;
   wire start_any = |start_level;
   // An empty synchroniser reads low, so arming waits until it holds the real pin level.
   wire start_seen_low = !start_any && sync_fill[3];

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= 2'h0;
         sync2 <= 2'h0;
         sync3 <= 2'h0;
         start_level <= 2'h0;
         sync_fill <= 4'h0;
      end else begin
         sync_fill <= {sync_fill[2:0], 1'b1};
         sync1 <= {reverse_start_input, forward_start_input};
         sync2 <= sync1;
         sync3 <= sync2;
         start_level <= (sync2 & sync3) | (start_level & (sync2 | sync3));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode.

   wire coast_none = (cfg.coast_time == `FPRS_COAST_NONE);
   wire stop_mode = (cfg.loss_sel == `FPRS_LOSS_STOP) && coast_none;
   wire cont_mode = (cfg.loss_sel == `FPRS_LOSS_CONT);
   wire ramp_mode = stop_mode || cont_mode;
   wire running = run_permit && !fault_output && !retry_excess_fault;

   ////////////////////////////////////////////////////////////////////////////////
   // Supply loss sequencer.

   fprs_pkg::fprs_loss_st_t loss_st, next_loss;

   // Only a running, untripped drive enters loss handling.
   always_comb begin
      next_loss = loss_st;
      case (loss_st)
         fprs_pkg::L_RUN: begin
            if (supply_loss && running) begin
               next_loss = ramp_mode ? fprs_pkg::L_DECEL : fprs_pkg::L_COAST;
            end
         end
         fprs_pkg::L_DECEL: begin
            if (output_at_zero) begin
               next_loss = fprs_pkg::L_STOPPED;
            end else if (!supply_loss && cont_mode) begin
               next_loss = fprs_pkg::L_RUN;
            end
         end
         fprs_pkg::L_STOPPED: begin
            // In stop mode the start must drop first, so a held start cannot rerun.
            if (!supply_loss && (cont_mode || !start_any)) begin
               next_loss = fprs_pkg::L_RUN;
            end
         end
         fprs_pkg::L_COAST: begin
            if (!supply_loss) begin
               next_loss = fprs_pkg::L_RUN;
            end
         end
         default: next_loss = fprs_pkg::L_RUN;
      endcase
   end

   // A dropped start in continue mode simply withdraws the run permit.
   wire next_run = start_any && (armed || !stop_mode) && !next_trip
      && (next_loss == fprs_pkg::L_RUN || next_loss == fprs_pkg::L_DECEL);
   wire next_y46 = (next_loss == fprs_pkg::L_DECEL) || (next_loss == fprs_pkg::L_STOPPED);
   wire next_reaccel = (loss_st == fprs_pkg::L_DECEL) && (next_loss == fprs_pkg::L_RUN);

   ////////////////////////////////////////////////////////////////////////////////
   // Retry eligibility and counts.

   logic [`FPRS_NFAULT-1:0] sel_mask, retry_mask;
   assign sel_mask = (cfg.retry_sel == 3'h0) ? `FPRS_MASK_SEL0 :
                     (cfg.retry_sel == 3'h1) ? `FPRS_MASK_SEL1 :
                     (cfg.retry_sel == 3'h2) ? `FPRS_MASK_SEL2 :
                     (cfg.retry_sel == 3'h3) ? `FPRS_MASK_SEL3 :
                     (cfg.retry_sel == 3'h4) ? `FPRS_MASK_SEL4 :
                     (cfg.retry_sel == 3'h5) ? `FPRS_MASK_SEL5 : '0;

   // Per fault: selected by the setting, and the power-up storage fault never.
   for (genvar i = 0; i < `FPRS_NFAULT; i++) begin : g_mask
      if (i == int'(fprs_pkg::F_PARAM_STORAGE)) begin : g_pe
         assign retry_mask[i] = sel_mask[i] && !powerup_storage_fault;
      end else begin : g_other
         assign retry_mask[i] = sel_mask[i];
      end
   end

   wire fault_hit = (int'(fault_code) < `FPRS_NFAULT) && retry_mask[fault_code];
   wire quiet = (cfg.retry_cnt != 8'h00) && (cfg.retry_cnt <= `FPRS_QUIET_MAX);
   wire loud = (cfg.retry_cnt > `FPRS_LOUD_BASE);
   wire [7:0] allowed = quiet ? cfg.retry_cnt : loud ? cfg.retry_cnt - `FPRS_LOUD_BASE : 8'h00;

   logic [11:0] wait_cnt;
   logic [13:0] run_cnt;
   logic [7:0] fail_cnt;
   wire [11:0] wait_eff = (cfg.wait_time == 12'h000) ? `FPRS_WAIT_DEFAULT : cfg.wait_time;
   wire [13:0] four_wait = {wait_eff, 2'b00};
   wire [13:0] succ_min = 14'(`FPRS_SUCC_MIN_MS / `FPRS_TICK_MS);
   wire tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Retry sequencer.

   fprs_pkg::fprs_retry_st_t rst_st, next_rst;
   wire wait_done = (wait_cnt >= wait_eff);
   wire succ = (run_cnt > four_wait) && (run_cnt >= succ_min);
   wire can_retry = fault_hit && (allowed != 8'h00) && (fail_cnt < allowed);
   wire excess = fault_hit && (allowed != 8'h00) && (fail_cnt >= allowed);
   wire trip_idle = fault_trip && (rst_st == fprs_pkg::R_IDLE || rst_st == fprs_pkg::R_WATCH);

   always_comb begin
      next_rst = rst_st;
      case (rst_st)
         fprs_pkg::R_IDLE, fprs_pkg::R_WATCH: begin
            if (fault_trip) begin
               next_rst = can_retry ? fprs_pkg::R_WAIT : fprs_pkg::R_LOCK;
            end else if (rst_st == fprs_pkg::R_WATCH && succ) begin
               next_rst = fprs_pkg::R_IDLE;
            end
         end
         fprs_pkg::R_WAIT: begin
            if (fault_trip && !fault_hit) begin
               next_rst = fprs_pkg::R_LOCK;
            end else if (wait_done) begin
               next_rst = fprs_pkg::R_WATCH;
            end
         end
         fprs_pkg::R_LOCK: begin
            if (fault_clear) begin
               next_rst = fprs_pkg::R_IDLE;
            end
         end
         default: next_rst = fprs_pkg::R_IDLE;
      endcase
   end

   wire do_retry = (rst_st == fprs_pkg::R_WAIT) && (next_rst == fprs_pkg::R_WATCH);
   wire success = (rst_st == fprs_pkg::R_WATCH) && succ && !fault_trip;
   wire manual_clr = (rst_st == fprs_pkg::R_LOCK) && fault_clear;
   wire counter_clear = counter_write && (counter_wdata == '0);
   // A trip in the clearing cycle still wins, so no fault is ever dropped.
   assign next_trip = fault_trip || (fault_output_raw && !do_retry && !manual_clr);
   wire next_excess = (trip_idle && excess) || (retry_excess_fault && !manual_clr);

   fprs_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .restart(rst_st != next_rst),
      .tick(tick)
   );

   // Timers restart on every retry state change, aligned with the tick phase.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_cnt <= 12'h000;
         run_cnt <= 14'h0000;
      end else begin
         wait_cnt <= (rst_st != next_rst) ? 12'h000 : wait_cnt + 12'(tick && !wait_done);
         run_cnt <= (rst_st != next_rst) ? 14'h0000 : run_cnt + 14'(tick && !(&run_cnt));
      end
   end

   // A zero write landing with a success clears the counter and still counts the success, leaving 1.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fail_cnt <= 8'h00;
         retry_success_counter <= '0;
      end else begin
         fail_cnt <= (success || manual_clr) ? 8'h00 : fail_cnt + 8'(do_retry);
         retry_success_counter <= success ? (counter_clear ? CNT_W'(1) :
            retry_success_counter + 1'b1) : counter_clear ? '0 : retry_success_counter;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State and output registers.

   wire next_y64 = (next_rst == fprs_pkg::R_WAIT);
   wire [7:0] tsel = cfg.term_sel;
   wire next_term = (tsel == `FPRS_TERM_LOSS_POS) ? next_y46 :
                    (tsel == `FPRS_TERM_LOSS_NEG) ? !next_y46 :
                    (tsel == `FPRS_TERM_RETRY_POS) ? next_y64 :
                    (tsel == `FPRS_TERM_RETRY_NEG) ? !next_y64 : 1'b0;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         loss_st <= fprs_pkg::L_RUN;
         rst_st <= fprs_pkg::R_IDLE;
         armed <= 1'b0;
         run_permit <= 1'b0;
         loss_decel_cmd <= 1'b0;
         output_cutoff <= 1'b0;
         reaccel_cmd <= 1'b0;
         restart_sel_power <= 1'b0;
         retry_reset_pulse <= 1'b0;
         retry_keep_thermal <= 1'b0;
         fault_output_raw <= 1'b0;
         fault_output <= 1'b0;
         retry_excess_fault <= 1'b0;
         loss_decel_status_out <= 1'b0;
         retry_active_status_out <= 1'b0;
         terminal_out <= 1'b0;
      end else begin
         loss_st <= next_loss;
         rst_st <= next_rst;
         armed <= (armed || start_seen_low) && (next_loss != fprs_pkg::L_STOPPED);
         run_permit <= next_run;
         loss_decel_cmd <= (next_loss == fprs_pkg::L_DECEL);
         output_cutoff <= (next_loss == fprs_pkg::L_COAST) || next_trip;
         reaccel_cmd <= next_reaccel;
         restart_sel_power <= !coast_none;
         retry_reset_pulse <= do_retry;
         retry_keep_thermal <= do_retry;
         fault_output_raw <= next_trip;
         fault_output <= next_trip && !(next_y64 && quiet);
         retry_excess_fault <= next_excess;
         loss_decel_status_out <= next_y46;
         retry_active_status_out <= next_y64;
         terminal_out <= next_term;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_loss_ramp_down: assert property (loss_st == fprs_pkg::L_RUN && supply_loss && running
      && ramp_mode |=> loss_decel_cmd && !output_cutoff) else $error("no loss ramp");
   a_stop_stays_off: assert property (loss_st == fprs_pkg::L_STOPPED && stop_mode
      && start_any |=> !run_permit) else $error("restart without off-on");
   a_coast_time_off: assert property (loss_st == fprs_pkg::L_RUN && supply_loss && running
      && !coast_none && cfg.loss_sel == `FPRS_LOSS_STOP |=> !loss_decel_cmd)
      else $error("stop mode not disabled");
   a_powerup_gate: assert property (stop_mode && !armed && start_any |=> !run_permit)
      else $error("start held at power-up ran");
   a_reaccel_once: assert property (loss_st == fprs_pkg::L_DECEL && cont_mode && !supply_loss
      && !output_at_zero |=> reaccel_cmd ##1 !reaccel_cmd) else $error("no reaccel pulse");
   a_loss_status: assert property (loss_st == fprs_pkg::L_STOPPED |-> loss_decel_status_out)
      else $error("loss status low while stopped");
   a_term_invert: assert property ($past(reset_n)
      && $past(cfg.term_sel) == `FPRS_TERM_LOSS_NEG
      |-> terminal_out == !loss_decel_status_out) else $error("terminal polarity");
   a_idle_no_loss: assert property (loss_st == fprs_pkg::L_RUN && !running
      |=> loss_st == fprs_pkg::L_RUN) else $error("loss handled while stopped");
   a_retry_release: assert property (rst_st == fprs_pkg::R_WAIT && wait_done && !fault_trip
      |=> retry_reset_pulse && !retry_active_status_out) else $error("retry not released");
   a_excess_trip: assert property (trip_idle && excess |=> retry_excess_fault
      && rst_st == fprs_pkg::R_LOCK) else $error("no excess fault");
   a_counter_clear: assert property (counter_clear && !success
      |=> retry_success_counter == '0) else $error("counter not cleared");
   a_abandon_wait: assert property (rst_st == fprs_pkg::R_WAIT && fault_trip && !fault_hit
      |=> rst_st == fprs_pkg::R_LOCK && fault_output) else $error("retry not abandoned");
   a_storage_norun: assert property (fault_trip && powerup_storage_fault
      && fault_code == fprs_pkg::F_PARAM_STORAGE |=> !retry_active_status_out)
      else $error("storage fault retried");

   c_retry_success: cover property (success);
   c_loss_stop: cover property (loss_st == fprs_pkg::L_DECEL ##1 loss_st == fprs_pkg::L_STOPPED);
   c_reaccel: cover property (reaccel_cmd);
   c_excess: cover property ($rose(retry_excess_fault));

endmodule

// [fprs_switch.sv]
////////////////////////////////////////////////////////////////////////////////
// External start switches as an outside controller drives them.
module fprs_switch (
   input wire logic core_clk,
   input wire logic want_fwd,
   input wire logic want_rev,
   output logic forward_start_input,
   output logic reverse_start_input
);
   timeunit 1ns;
   timeprecision 100ps;

   // Contacts settle a little after the edge, never on it.
   // The level is held as commanded, also through a supply loss.
   always @(posedge core_clk) begin
      forward_start_input <= #1 want_fwd;
      reverse_start_input <= #1 want_rev;
   end
endmodule

// [fprs_tick.sv]
module fprs_tick #(
   parameter int TICK_CYCLES = 25000000
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic restart,
   output logic tick
);

   localparam int CW = $clog2(TICK_CYCLES);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   generate
      if (TICK_CYCLES < 2) begin : g_chk
         $error("fprs_tick needs TICK_CYCLES of at least 2");
      end
   endgenerate

   logic [CW-1:0] count;
   wire at_last = (count == LAST);

   // Restart realigns the tick phase so a timed interval starts exactly at its event.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
         tick <= 1'b0;
      end else begin
         count <= (restart || at_last) ? '0 : count + 1'b1;
         tick <= at_last && !restart;
      end
   end

endmodule

// [test_fprs_seq.sv]
////////////////////////////////////////////////////////////////////////////////
module test_fprs_seq;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0, reset_n = 1'b0, want_fwd = 1'b1, want_rev = 1'b0;
   logic forward_start_input, reverse_start_input;
   logic supply_loss = 1'b0, output_at_zero = 1'b0, fault_trip = 1'b0;
   logic powerup_storage_fault = 1'b0, fault_clear = 1'b0, counter_write = 1'b0;
   fprs_pkg::fprs_fault_t fault_code = fprs_pkg::F_OC_ACCEL;
   logic [15:0] counter_wdata = 16'h0000;
   fprs_pkg::fprs_cfg_t cfg = '{14'h270f, 2'h1, 3'h1, 8'h01, 12'h001, 8'h2e};
   logic run_permit, loss_decel_cmd, output_cutoff, reaccel_cmd, restart_sel_power;
   logic retry_reset_pulse, retry_keep_thermal, fault_output, retry_excess_fault;
   logic loss_decel_status_out, retry_active_status_out, terminal_out;
   logic [15:0] retry_success_counter;
   int error_cnt = 0, n_tests = 0, i, k, sel, code, exp_succ = 0;
   bit pf, ok;

   always #2 core_clk = ~core_clk;

   // A short tick keeps every timed wait inside a few hundred cycles.
   fprs_seq #(.TICK_CYCLES(4), .CNT_W(16)) u_fprs_seq (.core_clk, .reset_n,
      .forward_start_input, .reverse_start_input, .supply_loss, .output_at_zero,
      .fault_trip, .fault_code, .powerup_storage_fault, .fault_clear, .counter_write,
      .counter_wdata, .cfg, .run_permit, .loss_decel_cmd, .output_cutoff, .reaccel_cmd,
      .restart_sel_power, .retry_reset_pulse, .retry_keep_thermal, .fault_output,
      .retry_excess_fault, .loss_decel_status_out, .retry_active_status_out,
      .terminal_out, .retry_success_counter);
   fprs_switch u_fprs_switch (.core_clk, .want_fwd, .want_rev, .forward_start_input,
      .reverse_start_input);

   ////////////////////////////////////////////////////////////////////////////////
   // Which faults retry, per selection; codes 6, 7 and 11 are the thermal trips.
   function automatic bit eligible(int s, int c, bit p);
      if (p && c == 15) return 1'b0;
      case (s)
         0: return 1'b1;
         1: return c <= 2;
         2: return c >= 3 && c <= 5;
         3: return c <= 5;
         4: return !(c == 6 || c == 7 || c == 11);
         default: return c == 0 || c == 2;
      endcase
   endfunction

   task automatic step(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // A wait that used up its bound ends the run.
   task automatic bound(int lim, string what);
      if (i >= lim) begin
         error_cnt++;
         $display("mismatch %s expected done seen timeout", what);
         stop_test();
      end
   endtask

   task automatic do_reset(int n);
      reset_n = 1'b0;
      step(n);
      reset_n = 1'b1;
      step(1);
   endtask

   task automatic wait_run(logic lvl);
      for (i = 0; i < 30 && run_permit !== lvl; i++) step(1);
      bound(30, "run_permit");
   endtask

   task automatic toggle_start();
      want_fwd = 1'b0;
      step(8);
      want_fwd = 1'b1;
      wait_run(1'b1);
   endtask

   // The trip pulse lasts one cycle; its answer is visible one cycle later.
   task automatic trip(int c);
      fault_code = fprs_pkg::fprs_fault_t'(5'(c));
      fault_trip = 1'b1;
      step(1);
      fault_trip = 1'b0;
      step(1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'he25d2d30));
      do_reset(6);
      step(10);
      chk("held start", 16'h0, 16'(run_permit));
      toggle_start();
      $display("test power_up_start done");
      // Stop mode: ramp to zero, stay stopped until the start is cycled.
      supply_loss = 1'b1;
      step(2);
      chk("loss cmd", 16'h1, 16'(loss_decel_cmd));
      chk("terminal 46", 16'h1, 16'(terminal_out));
      step(5);
      output_at_zero = 1'b1;
      step(2);
      chk("loss cmd end", 16'h0, 16'(loss_decel_cmd));
      supply_loss = 1'b0;
      step(10);
      chk("stopped run", 16'h0, 16'(run_permit));
      chk("stopped status", 16'h1, 16'(loss_decel_status_out));
      cfg.term_sel = 8'h92;
      step(2);
      chk("terminal 146", 16'h0, 16'(terminal_out));
      toggle_start();
      output_at_zero = 1'b0;
      chk("status cleared", 16'h0, 16'(loss_decel_status_out));
      $display("test stop_mode done");
      // Continue mode: supply back re-accelerates; loss while stopped does nothing.
      cfg.loss_sel = 2'h2;
      do_reset(1);
      wait_run(1'b1);
      supply_loss = 1'b1;
      step(4);
      supply_loss = 1'b0;
      step(1);
      chk("reaccel", 16'h1, 16'(reaccel_cmd));
      chk("reaccel status", 16'h0, 16'(loss_decel_status_out));
      want_fwd = 1'b0;
      wait_run(1'b0);
      supply_loss = 1'b1;
      step(3);
      chk("idle loss", 16'h0, 16'(loss_decel_cmd | loss_decel_status_out));
      supply_loss = 1'b0;
      $display("test continue_mode done");
      // Coast selection, and stop mode overridden by a restart coast time.
      for (k = 0; k < 2; k++) begin
         cfg.loss_sel = 2'(k);
         cfg.coast_time = (k == 0) ? 14'h270f : 14'h0005;
         want_fwd = 1'b0;
         do_reset(1);
         want_fwd = 1'b1;
         wait_run(1'b1);
         supply_loss = 1'b1;
         step(2);
         chk("cutoff", 16'h1, 16'(output_cutoff));
         chk("no ramp", 16'h0, 16'(loss_decel_cmd));
         chk("restart sel", 16'(k), 16'(restart_sel_power));
         supply_loss = 1'b0;
      end
      $display("test cutoff done");
      // Random selections and codes against the eligibility table.
      for (k = 0; k < 24; k++) begin
         sel = $urandom % 6;
         code = $urandom % 21;
         pf = $urandom % 2;
         cfg.retry_sel = 3'(sel);
         cfg.term_sel = (k % 2) ? 8'ha4 : 8'h40;
         powerup_storage_fault = pf;
         do_reset(1);
         trip(code);
         ok = eligible(sel, code, pf);
         chk("retry active", 16'(ok), 16'(retry_active_status_out));
         chk("quiet fault", 16'(!ok), 16'(fault_output));
         chk("terminal retry", 16'(ok ^ (k % 2)), 16'(terminal_out));
      end
      powerup_storage_fault = 1'b0;
      $display("test retry_select done");
      // Loud retry, waiting time, excess trip, then a counted success.
      cfg.retry_sel = 3'h0;
      cfg.retry_cnt = 8'h65;
      cfg.wait_time = 12'h002;
      do_reset(1);
      trip(3);
      chk("loud fault", 16'h1, 16'(fault_output));
      for (i = 0; i < 40 && retry_reset_pulse !== 1'b1; i++) step(1);
      bound(40, "retry pulse");
      chk("wait cycles", 16'h1, 16'(i >= 7 && i <= 10));
      chk("keep thermal", 16'h1, 16'(retry_keep_thermal));
      chk("fault cleared", 16'h0, 16'(fault_output));
      trip(3);
      chk("excess", 16'h1, 16'(retry_excess_fault));
      fault_clear = 1'b1;
      step(1);
      fault_clear = 1'b0;
      // A storage fault during the wait is not eligible and ends the retry.
      do_reset(1);
      trip(0);
      powerup_storage_fault = 1'b1;
      trip(15);
      chk("abandon", 16'h1, 16'(fault_output && !retry_active_status_out));
      powerup_storage_fault = 1'b0;
      cfg.wait_time = 12'h001;
      do_reset(1);
      trip(0);
      for (i = 0; i < 40 && retry_reset_pulse !== 1'b1; i++) step(1);
      bound(40, "retry pulse");
      for (i = 0; i < 300 && retry_success_counter !== 16'(exp_succ + 1); i++) step(1);
      bound(300, "success");
      exp_succ++;
      chk("success delay", 16'h1, 16'(i >= 123));
      chk("success count", 16'(exp_succ), retry_success_counter);
      for (k = 5; k >= 0; k -= 5) begin
         counter_wdata = 16'(k);
         counter_write = 1'b1;
         step(1);
         counter_write = 1'b0;
         step(1);
         exp_succ = (k == 0) ? 0 : exp_succ;
         chk("counter write", 16'(exp_succ), retry_success_counter);
      end
      $display("test retry_count done");
      stop_test();
   end
endmodule
